// File: rtl/uart_pkg.sv
// constants shared by the asynchronous serial channel and its transmit buffer
package uart_pkg;
   // ==========================================================================
   // character length codes
   localparam logic [1:0] LEN_7 = 2'h0;
   localparam logic [1:0] LEN_8 = 2'h1;
   localparam logic [1:0] LEN_9 = 2'h2;
   localparam logic [3:0] BITS_7 = 4'h7;
   localparam logic [3:0] BITS_8 = 4'h8;
   localparam logic [3:0] BITS_9 = 4'h9;
   localparam int unsigned CHAR_MAX = 9;
   // ==========================================================================
   // count source taps
   localparam logic [1:0] SRC_UNDIV = 2'h0;
   localparam logic [1:0] SRC_DIV8  = 2'h1;
   localparam logic [1:0] SRC_DIV32 = 2'h2;
   localparam logic [1:0] SRC_SUB   = 2'h3;
   localparam logic [4:0] DIV8_LAST  = 5'h07;
   localparam logic [4:0] DIV32_LAST = 5'h1f;
   // ==========================================================================
   // oversampling: 16 ticks per bit, start bit checked at its centre
   localparam logic [3:0] PHASE_LAST  = 4'hf;
   localparam logic [3:0] START_CHECK = 4'h7;
   localparam int unsigned BRG_W      = 8;
   localparam int unsigned FIFO_DEPTH = 8;
endpackage : uart_pkg

// File: rtl/stream_if.sv
// valid/ready word stream between the channel and its transmit buffer
`timescale 1ns/1ps
interface stream_if #(
   parameter int unsigned W = 9
);
   logic         push_valid;
   logic         push_ready;
   logic [W-1:0] push_data;
   logic         pop_valid;
   logic         pop_ready;
   logic [W-1:0] pop_data;
   modport buffer (input push_valid, push_data, pop_ready,
                   output push_ready, pop_valid, pop_data);
   modport user   (output push_valid, push_data, pop_ready,
                   input push_ready, pop_valid, pop_data);
endinterface : stream_if

// File: rtl/tx_fifo.sv
// shift-register fifo whose head word sits in a register
`timescale 1ns/1ps
module tx_fifo #(
   parameter int unsigned W     = 9,
   parameter int unsigned DEPTH = 8
) (
   input  wire logic clk_sys_i,
   input  wire logic srst_i,
   stream_if.buffer  s
);
   localparam int unsigned CW = $clog2(DEPTH + 1);
   logic [W-1:0]  mem [DEPTH];
   logic [CW-1:0] count;
   wire           do_push = s.push_valid && s.push_ready;
   wire           do_pop  = s.pop_valid && s.pop_ready;
   wire  [CW-1:0] wr_slot = do_pop ? count - CW'(1) : count;

   assign s.push_ready = (count != CW'(DEPTH));
   assign s.pop_valid  = (count != '0);
   assign s.pop_data   = mem[0];

   // ==========================================================================
   // storage: a pop shifts every word one place toward the head
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         count <= '0;
      end else begin
         count <= count + CW'(do_push) - CW'(do_pop);
      end
   end

   genvar i;
   generate
      for (i = 0; i < DEPTH; i++) begin : g_slot
         always_ff @(posedge clk_sys_i) begin
            if (srst_i) begin
               mem[i] <= '0;
            end else if (do_push && wr_slot == CW'(i)) begin
               mem[i] <= s.push_data;
            end else if (do_pop) begin
               mem[i] <= (i + 1 < DEPTH) ? mem[(i + 1) % DEPTH] : '0;
            end
         end
      end
   endgenerate

   property p_no_overfill;
      @(posedge clk_sys_i) disable iff (srst_i)
      count <= CW'(DEPTH);
   endproperty
   a_no_overfill: assert property (p_no_overfill) else $error("fifo count exceeds depth");
endmodule : tx_fifo

// File: rtl/uart_channel.sv
// asynchronous serial channel: rate generator, transmitter and receiver
// Summary of operation
// - frame is one start bit then a 7, 8 or 9 bit character
// - parity odd, even or none; with none no parity bit is sent or expected
// - frame ends with one or two stop bits as configured
// - internal rate is chosen tap divided by 16(n+1); taps undivided, /8, /32, sub-clock
// - divisor n is an 8-bit software value from 00 to ff
// - external rate is the clock pin frequency divided by 16(n+1)
// - only channel 0 may use the external clock; other channels always internal
// - clock select 0 picks internal source, 1 picks the external pin
// - transmit starts only with transmit enabled and buffer not empty
// - receive starts only with receive enabled and a start bit detected
// - transmit interrupt on buffer-to-shifter move, or on shift-out end, by cause select
// - receive interrupt when a character moves into the receive buffer
// - overrun when a new character arrives before the buffer was read
// - on overrun the buffer is overwritten and no receive interrupt is raised
// - framing error when configured stop bits are not seen
// - parity error when ones count disagrees with odd or even setting
// - error sum set whenever overrun, framing or parity error occurs
// - sleep mode lets one addressed station among many receive
// - serial output high from mode select to first transfer; floats if open-drain
// - clock pin is a plain port unless the external clock is selected
// - in sleep mode only characters with most significant bit 1 are accepted
// - each bit lasts 16(n+1) cycles of the selected count source
`timescale 1ns/1ps
module uart_channel #(
   parameter bit HAS_EXT_CLK = 1'b1
) (
   input  wire logic       clk_sys_i,
   input  wire logic       srst_i,
   input  wire logic       uart_mode_i,
   input  wire logic [1:0] char_len_i,
   input  wire logic       parity_en_i,
   input  wire logic       parity_odd_i,
   input  wire logic       two_stop_i,
   input  wire logic [1:0] src_sel_i,
   input  wire logic       ext_clk_sel_i,
   input  wire logic [7:0] brg_div_i,
   input  wire logic       tx_en_i,
   input  wire logic       rx_en_i,
   input  wire logic       tx_int_cause_i,
   input  wire logic       sleep_i,
   input  wire logic       open_drain_i,
   input  wire logic [8:0] tx_data_i,
   input  wire logic       tx_valid_i,
   output wire logic       tx_ready_o,
   output wire logic       tx_buf_empty_o,
   output logic            tx_irq_o,
   output logic [8:0]      rx_data_o,
   output logic            rx_full_o,
   input  wire logic       rx_read_i,
   output logic            rx_irq_o,
   output logic            overrun_o,
   output logic            framing_o,
   output logic            parity_err_o,
   output logic            err_sum_o,
   input  wire logic       err_clr_i,
   input  wire logic       serial_in_i,
   output logic            serial_out_o,
   output wire logic       serial_out_oe_o,
   input  wire logic       ext_rate_clock_pin_i,
   input  wire logic       subclock_tap_i,
   output logic            ext_rate_clock_port_o
);
   // ==========================================================================
   // helpers
   function automatic logic [3:0] char_bits(input logic [1:0] len);
      unique case (len)
         uart_pkg::LEN_7: char_bits = uart_pkg::BITS_7;
         uart_pkg::LEN_8: char_bits = uart_pkg::BITS_8;
         default:         char_bits = uart_pkg::BITS_9;
      endcase
   endfunction

   function automatic logic [8:0] len_mask(input logic [1:0] len);
      unique case (len)
         uart_pkg::LEN_7: len_mask = 9'h07f;
         uart_pkg::LEN_8: len_mask = 9'h0ff;
         default:         len_mask = 9'h1ff;
      endcase
   endfunction

   // ==========================================================================
   // pin synchronisers; first stage feeds only the second
   logic [1:0] ext_sync;
   logic [1:0] sub_sync;
   logic [1:0] rx_sync;
   logic       ext_prev;
   logic       sub_prev;
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         ext_sync <= 2'h3;
         sub_sync <= 2'h0;
         rx_sync  <= 2'h3;
         ext_prev <= 1'b1;
         sub_prev <= 1'b0;
      end else begin
         ext_sync <= {ext_sync[0], ext_rate_clock_pin_i};
         sub_sync <= {sub_sync[0], subclock_tap_i};
         rx_sync  <= {rx_sync[0], serial_in_i};
         ext_prev <= ext_sync[1];
         sub_prev <= sub_sync[1];
      end
   end
   wire rx_line  = rx_sync[1];
   wire ext_rise = ext_sync[1] && !ext_prev;
   wire sub_rise = sub_sync[1] && !sub_prev;

   // ==========================================================================
   // count source and rate generator
   logic [4:0] pre_cnt;
   logic [7:0] brg_cnt;
   // a channel without the pin ignores the select bit entirely
   wire ext_active = HAS_EXT_CLK && ext_clk_sel_i;
   wire tap_en = (src_sel_i == uart_pkg::SRC_UNDIV) ? 1'b1 :
                 (src_sel_i == uart_pkg::SRC_DIV8)  ? (pre_cnt[2:0] == uart_pkg::DIV8_LAST[2:0]) :
                 (src_sel_i == uart_pkg::SRC_DIV32) ? (pre_cnt == uart_pkg::DIV32_LAST) :
                 sub_rise;
   wire src_en = ext_active ? ext_rise : tap_en;
   wire tick16 = uart_mode_i && src_en && (brg_cnt == 8'h00);

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         pre_cnt               <= 5'h00;
         brg_cnt               <= 8'h00;
         ext_rate_clock_port_o <= 1'b0;
      end else begin
         pre_cnt <= pre_cnt + 5'h01;
         if (!uart_mode_i) begin
            brg_cnt <= 8'h00;
         end else if (src_en) begin
            brg_cnt <= (brg_cnt == 8'h00) ? brg_div_i : brg_cnt - 8'h01;
         end
         ext_rate_clock_port_o <= ext_active ? 1'b0 : ext_sync[1];
      end
   end

   // ==========================================================================
   // transmit buffer
   stream_if #(.W(uart_pkg::CHAR_MAX)) txq ();
   tx_fifo #(.W(uart_pkg::CHAR_MAX), .DEPTH(uart_pkg::FIFO_DEPTH)) u_txq (
      .clk_sys_i (clk_sys_i),
      .srst_i    (srst_i),
      .s         (txq.buffer)
   );
   assign txq.push_valid = tx_valid_i;
   assign txq.push_data  = tx_data_i;
   assign tx_ready_o     = txq.push_ready;
   assign tx_buf_empty_o = !txq.pop_valid;

   // ==========================================================================
   // transmitter
   typedef enum logic [4:0] {
      TX_IDLE = 5'b00001, TX_START = 5'b00010, TX_DATA = 5'b00100,
      TX_PAR  = 5'b01000, TX_STOP  = 5'b10000
   } tx_state_t;
   tx_state_t  tx_state;
   logic [3:0] tx_phase;
   logic [3:0] tx_cnt;
   logic [8:0] tx_shift;
   logic       tx_par;
   wire [8:0] tx_word  = txq.pop_data & len_mask(char_len_i);
   wire       tx_start = uart_mode_i && tx_en_i && txq.pop_valid && tx_state == TX_IDLE;
   wire       tx_bit   = tick16 && tx_phase == uart_pkg::PHASE_LAST;
   wire       tx_last  = tx_cnt == char_bits(char_len_i) - 4'h1;
   assign txq.pop_ready = tx_start;
   // a plain driver holds the line whenever the mode is on; open-drain only pulls low
   assign serial_out_oe_o = uart_mode_i && (!open_drain_i || !serial_out_o);

   always_ff @(posedge clk_sys_i) begin
      if (srst_i || !uart_mode_i) begin
         tx_state     <= TX_IDLE;
         tx_phase     <= 4'h0;
         tx_cnt       <= 4'h0;
         tx_shift     <= 9'h000;
         tx_par       <= 1'b0;
         serial_out_o <= 1'b1;
         tx_irq_o     <= 1'b0;
      end else begin
         tx_irq_o <= 1'b0;
         if (tick16 && tx_state != TX_IDLE) begin
            tx_phase <= tx_phase + 4'h1;
         end
         unique case (tx_state)
            TX_IDLE: begin
               if (tx_start) begin
                  tx_shift     <= tx_word;
                  tx_par       <= ^tx_word ^ parity_odd_i;
                  tx_phase     <= 4'h0;
                  serial_out_o <= 1'b0;
                  tx_state     <= TX_START;
                  tx_irq_o     <= !tx_int_cause_i;
               end
            end
            TX_START: begin
               if (tx_bit) begin
                  serial_out_o <= tx_shift[0];
                  tx_shift     <= tx_shift >> 1;
                  tx_cnt       <= 4'h0;
                  tx_state     <= TX_DATA;
               end
            end
            TX_DATA: begin
               if (tx_bit) begin
                  if (tx_last) begin
                     serial_out_o <= parity_en_i ? tx_par : 1'b1;
                     tx_state     <= parity_en_i ? TX_PAR : TX_STOP;
                     tx_cnt       <= 4'h0;
                  end else begin
                     serial_out_o <= tx_shift[0];
                     tx_shift     <= tx_shift >> 1;
                     tx_cnt       <= tx_cnt + 4'h1;
                  end
               end
            end
            TX_PAR: begin
               if (tx_bit) begin
                  serial_out_o <= 1'b1;
                  tx_state     <= TX_STOP;
               end
            end
            TX_STOP: begin
               if (tx_bit) begin
                  if (two_stop_i && tx_cnt == 4'h0) begin
                     tx_cnt <= 4'h1;
                  end else begin
                     tx_state <= TX_IDLE;
                     tx_irq_o <= tx_int_cause_i;
                  end
               end
            end
            default: tx_state <= TX_IDLE;
         endcase
      end
   end

   // ==========================================================================
   // receiver
   typedef enum logic [4:0] {
      RX_IDLE = 5'b00001, RX_START = 5'b00010, RX_DATA = 5'b00100,
      RX_PAR  = 5'b01000, RX_STOP  = 5'b10000
   } rx_state_t;
   rx_state_t  rx_state;
   logic [3:0] rx_phase;
   logic [3:0] rx_cnt;
   logic [8:0] rx_shift;
   logic       rx_pbit;
   logic       rx_ferr;
   logic       rx_done;
   wire        rx_sample = tick16 && rx_phase == uart_pkg::PHASE_LAST;
   wire        rx_last   = rx_cnt == char_bits(char_len_i) - 4'h1;

   always_ff @(posedge clk_sys_i) begin
      if (srst_i || !uart_mode_i) begin
         rx_state <= RX_IDLE;
         rx_phase <= 4'h0;
         rx_cnt   <= 4'h0;
         rx_shift <= 9'h000;
         rx_pbit  <= 1'b0;
         rx_ferr  <= 1'b0;
         rx_done  <= 1'b0;
      end else begin
         rx_done <= 1'b0;
         if (tick16 && rx_state != RX_IDLE) begin
            rx_phase <= rx_phase + 4'h1;
         end
         unique case (rx_state)
            RX_IDLE: begin
               if (rx_en_i && tick16 && !rx_line) begin
                  rx_phase <= 4'h0;
                  rx_ferr  <= 1'b0;
                  rx_state <= RX_START;
               end
            end
            RX_START: begin
               // a glitch shorter than half a bit is dropped here
               if (tick16 && rx_phase == uart_pkg::START_CHECK) begin
                  rx_phase <= 4'h0;
                  rx_cnt   <= 4'h0;
                  rx_state <= rx_line ? RX_IDLE : RX_DATA;
               end
            end
            RX_DATA: begin
               if (rx_sample) begin
                  rx_shift <= {rx_line, rx_shift[8:1]};
                  rx_cnt   <= rx_last ? 4'h0 : rx_cnt + 4'h1;
                  if (rx_last) begin
                     rx_state <= parity_en_i ? RX_PAR : RX_STOP;
                  end
               end
            end
            RX_PAR: begin
               if (rx_sample) begin
                  rx_pbit  <= rx_line;
                  rx_state <= RX_STOP;
               end
            end
            RX_STOP: begin
               if (rx_sample) begin
                  if (!rx_line) begin
                     rx_ferr <= 1'b1;
                  end
                  if (two_stop_i && rx_cnt == 4'h0) begin
                     rx_cnt <= 4'h1;
                  end else begin
                     rx_done  <= 1'b1;
                     rx_state <= RX_IDLE;
                  end
               end
            end
            default: rx_state <= RX_IDLE;
         endcase
      end
   end

   // ==========================================================================
   // receive buffer and error flags; a set beats a clear in the same cycle
   wire [8:0] rx_word = rx_shift >> (4'h9 - char_bits(char_len_i));
   wire       rx_msb  = rx_word[char_bits(char_len_i) - 4'h1];
   wire       accept  = rx_done && !(sleep_i && !rx_msb);
   wire       ovr_set = accept && rx_full_o && !rx_read_i;
   wire       frm_set = accept && rx_ferr;
   wire       par_set = accept && parity_en_i && ((^rx_word ^ rx_pbit) != parity_odd_i);

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         rx_data_o    <= 9'h000;
         rx_full_o    <= 1'b0;
         rx_irq_o     <= 1'b0;
         overrun_o    <= 1'b0;
         framing_o    <= 1'b0;
         parity_err_o <= 1'b0;
         err_sum_o    <= 1'b0;
      end else begin
         if (accept) begin
            rx_data_o <= rx_word;
         end
         rx_full_o    <= accept || (rx_full_o && !rx_read_i);
         rx_irq_o     <= accept && !ovr_set;
         overrun_o    <= ovr_set || (overrun_o && !err_clr_i);
         framing_o    <= frm_set || (framing_o && !err_clr_i);
         parity_err_o <= par_set || (parity_err_o && !err_clr_i);
         err_sum_o    <= ovr_set || frm_set || par_set || (err_sum_o && !err_clr_i);
      end
   end

   // ==========================================================================
   // checks
   property p_tx_cause0;
      @(posedge clk_sys_i) disable iff (srst_i)
      (tx_start && !tx_int_cause_i) |=> tx_irq_o && tx_state == TX_START;
   endproperty
   a_tx_cause0: assert property (p_tx_cause0) else $error("no irq on buffer move");

   property p_tx_gate;
      @(posedge clk_sys_i) disable iff (srst_i)
      (tx_state == TX_IDLE ##1 tx_state == TX_START) |-> $past(tx_en_i) && !serial_out_o;
   endproperty
   a_tx_gate: assert property (p_tx_gate) else $error("transmit began while disabled");

   property p_idle_high;
      @(posedge clk_sys_i) disable iff (srst_i)
      (uart_mode_i && tx_state == TX_IDLE) |-> serial_out_o && (serial_out_oe_o != open_drain_i);
   endproperty
   a_idle_high: assert property (p_idle_high) else $error("idle line not released high");

   property p_ovr_no_irq;
      @(posedge clk_sys_i) disable iff (srst_i)
      ovr_set |=> overrun_o && !rx_irq_o && rx_data_o == $past(rx_word);
   endproperty
   a_ovr_no_irq: assert property (p_ovr_no_irq) else $error("overrun mishandled");

   property p_err_sum;
      @(posedge clk_sys_i) disable iff (srst_i)
      (overrun_o || framing_o || parity_err_o) |-> err_sum_o;
   endproperty
   a_err_sum: assert property (p_err_sum) else $error("error sum missing");

   property p_par_off;
      @(posedge clk_sys_i) disable iff (srst_i)
      (rx_done && !parity_en_i && !parity_err_o && !err_clr_i) |=> !parity_err_o;
   endproperty
   a_par_off: assert property (p_par_off) else $error("parity error without parity");

   property p_sleep;
      @(posedge clk_sys_i) disable iff (srst_i)
      (rx_done && sleep_i && !rx_msb) |=> !rx_irq_o && $stable(rx_data_o);
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep accepted address-less char");

   property p_rx_gate;
      @(posedge clk_sys_i) disable iff (srst_i)
      (rx_state == RX_IDLE ##1 rx_state == RX_START) |-> $past(rx_en_i) && $past(!rx_line);
   endproperty
   a_rx_gate: assert property (p_rx_gate) else $error("receive began without start bit");

   property p_no_ext;
      @(posedge clk_sys_i) disable iff (srst_i)
      (!HAS_EXT_CLK || !ext_clk_sel_i) |-> src_en == tap_en;
   endproperty
   a_no_ext: assert property (p_no_ext) else $error("external clock used wrongly");

   property p_brg;
      @(posedge clk_sys_i) disable iff (srst_i)
      (tick16 && brg_div_i == 8'h01 && src_sel_i == uart_pkg::SRC_UNDIV && !ext_active)
         ##1 (uart_mode_i && brg_div_i == 8'h01 && src_sel_i == uart_pkg::SRC_UNDIV
              && !ext_active) |-> !tick16 ##1
         (tick16 || !(uart_mode_i && src_sel_i == uart_pkg::SRC_UNDIV && !ext_active));
   endproperty
   a_brg: assert property (p_brg) else $error("rate generator period wrong");
endmodule : uart_channel

// File: dv/peer_uart.sv
// peer serial station that sends frames to the channel and reads its frames
`timescale 1ns/1ps
module peer_uart #(
   parameter int BIT = 32
) (
   input  wire logic clk_sys_i,
   input  wire logic line_i,
   output logic      line_o
);
   initial line_o = 1'b1;
   task automatic put(input logic b);
      line_o <= b;
      repeat (BIT) @(posedge clk_sys_i);
   endtask
   // ==========================================================================
   // sender: bp flips parity, bs holds the line low 5/8 of a bit before the first stop
   task automatic send(input logic [8:0] d, input int nb, input bit pe, od, ts, bp, bs);
      logic p;
      p = od ^ bp;
      put(1'b0);
      for (int i = 0; i < nb; i++) begin
         p ^= d[i];
         put(d[i]);
      end
      if (pe) put(p);
      if (bs) line_o <= 1'b0;
      if (bs) repeat (BIT * 5 / 8) @(posedge clk_sys_i);
      put(1'b1);
      if (ts) put(1'b1);
   endtask
   // ==========================================================================
   // receiver: samples mid-bit, so a wrong bit time shows up as wrong data
   task automatic recv(input int nb, input bit pe, output logic [8:0] d, output logic p, s);
      d = '0;
      p = 1'b0;
      @(negedge line_i);
      repeat (BIT / 2) @(posedge clk_sys_i);
      for (int i = 0; i < nb; i++) begin
         repeat (BIT) @(posedge clk_sys_i);
         d[i] = line_i;
      end
      if (pe) repeat (BIT) @(posedge clk_sys_i);
      if (pe) p = line_i;
      repeat (BIT) @(posedge clk_sys_i);
      s = line_i;
   endtask
endmodule // peer_uart

// File: dv/uart_channel_tb.sv
// self-checking bench for the asynchronous serial channel
`timescale 1ns/1ps
module uart_channel_tb;
   localparam int BIT = 32; // n = 1 on the undivided tap
   logic clk_sys_i, srst_i, uart_mode_i, parity_en_i, parity_odd_i, two_stop_i, ext_clk_sel_i;
   logic tx_en_i, rx_en_i, tx_int_cause_i, sleep_i, open_drain_i, tx_valid_i, rx_read_i;
   logic err_clr_i, serial_in_i, ext_rate_clock_pin_i, subclock_tap_i, line, p, s;
   logic tx_ready_o, tx_buf_empty_o, tx_irq_o, rx_full_o, rx_irq_o, overrun_o, framing_o;
   logic parity_err_o, err_sum_o, serial_out_o, serial_out_oe_o, ext_rate_clock_port_o;
   logic [1:0] char_len_i, src_sel_i;
   logic [7:0] brg_div_i;
   logic [8:0] tx_data_i, rx_data_o, d;
   int errors = 0, checked = 0, tx_irqs = 0, rx_irqs = 0;
   assign line = serial_out_oe_o ? serial_out_o : 1'b1; // released line is pulled up
   uart_channel #(.HAS_EXT_CLK(1'b1)) u_dut (
      .clk_sys_i, .srst_i, .uart_mode_i, .char_len_i, .parity_en_i, .parity_odd_i,
      .two_stop_i, .src_sel_i, .ext_clk_sel_i, .brg_div_i, .tx_en_i, .rx_en_i,
      .tx_int_cause_i, .sleep_i, .open_drain_i, .tx_data_i, .tx_valid_i, .tx_ready_o,
      .tx_buf_empty_o, .tx_irq_o, .rx_data_o, .rx_full_o, .rx_read_i, .rx_irq_o,
      .overrun_o, .framing_o, .parity_err_o, .err_sum_o, .err_clr_i, .serial_in_i,
      .serial_out_o, .serial_out_oe_o, .ext_rate_clock_pin_i, .subclock_tap_i,
      .ext_rate_clock_port_o);
   peer_uart #(.BIT(BIT)) u_peer (.clk_sys_i, .line_i(line), .line_o(serial_in_i));
   initial begin
      clk_sys_i = 1'b0;
      forever #4 clk_sys_i = ~clk_sys_i;
   end
   always @(posedge clk_sys_i) begin
      if (tx_irq_o === 1'b1) tx_irqs++;
      if (rx_irq_o === 1'b1) rx_irqs++;
   end
   // pin clock: one rising edge every 4 cycles while selected, held high otherwise
   always begin
      cyc(2);
      ext_rate_clock_pin_i <= ext_clk_sel_i ? !ext_rate_clock_pin_i : 1'b1;
   end
   // ==========================================================================
   // shared tasks
   task automatic chk(input string nm, input logic [8:0] exp, got);
      checked++;
      if (got !== exp) errors++;
      if (got !== exp) $display("ERROR %s expected %h seen %h", nm, exp, got);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask
   task automatic wr(input logic [8:0] v);
      @(posedge clk_sys_i);
      tx_data_i <= v;
      tx_valid_i <= 1'b1;
      @(posedge clk_sys_i);
      tx_valid_i <= 1'b0;
   endtask
   task automatic cfg(input logic [1:0] len, input bit pe, od, ts);
      char_len_i <= len;
      parity_en_i <= pe;
      parity_odd_i <= od;
      two_stop_i <= ts;
   endtask
   task automatic clr();
      @(posedge clk_sys_i);
      {rx_read_i, err_clr_i} <= 2'h3;
      @(posedge clk_sys_i);
      {rx_read_i, err_clr_i} <= 2'h0;
   endtask
   // ==========================================================================
   // scenarios
   task automatic t_idle();
      chk("serial_out", 1'b1, serial_out_o);
      chk("tx_buf_empty", 1'b1, tx_buf_empty_o);
      open_drain_i <= 1'b1;
      cyc(4);
      chk("clock_port", 1'b1, ext_rate_clock_port_o);
      chk("out_enable", 1'b0, serial_out_oe_o);
      open_drain_i <= 1'b0;
      cyc(1);
   endtask
   task automatic t_tx();
      int b;
      for (int i = 0; i < 3; i++) begin
         b = tx_irqs;
         cfg(i[1:0], i != 2, i == 0, i == 2);
         tx_int_cause_i <= i[0];
         fork
            u_peer.recv(7 + i, i != 2, d, p, s);
            wr(9'h1a4);
         join
         cyc(2 * BIT);
         chk("tx_data", 9'h1a4 & ~(9'h1ff << (7 + i)), d);
         chk("tx_parity", 1'(i != 2), p);
         chk("tx_stop", 1'b1, s);
         chk("tx_irqs", 9'h1, 9'(tx_irqs - b));
      end
   endtask
   task automatic t_rx();
      int b;
      for (int i = 0; i < 3; i++) begin
         b = rx_irqs;
         cfg(i[1:0], i != 2, i == 0, i == 2);
         u_peer.send(9'h1a4, 7 + i, i != 2, i == 0, i == 2, 0, 0);
         cyc(4);
         chk("rx_data", 9'h1a4 & ~(9'h1ff << (7 + i)), rx_data_o);
         chk("rx_irqs", 9'h1, 9'(rx_irqs - b));
         chk("err_sum", 1'b0, err_sum_o);
         clr();
      end
   endtask
   task automatic t_err();
      cfg(2'h1, 1, 0, 0);
      u_peer.send(9'h0a4, 8, 1, 0, 0, 1, 0);
      cyc(4);
      chk("parity_err", 1'b1, parity_err_o);
      chk("err_sum", 1'b1, err_sum_o);
      chk("framing", 1'b0, framing_o);
      clr();
      u_peer.send(9'h0a4, 8, 1, 0, 0, 0, 1);
      chk("framing", 1'b1, framing_o);
      chk("parity_err", 1'b0, parity_err_o);
      clr();
   endtask
   task automatic t_ovr();
      int b;
      b = rx_irqs;
      cfg(2'h1, 0, 0, 0);
      u_peer.send(9'h011, 8, 0, 0, 0, 0, 0);
      u_peer.send(9'h022, 8, 0, 0, 0, 0, 0);
      cyc(4);
      chk("overrun", 1'b1, overrun_o);
      chk("err_sum", 1'b1, err_sum_o);
      chk("rx_data", 9'h022, rx_data_o);
      chk("rx_irqs", 9'h1, 9'(rx_irqs - b));
      clr();
   endtask
   task automatic t_sleep();
      int b;
      b = rx_irqs;
      cfg(2'h2, 0, 0, 0);
      sleep_i <= 1'b1;
      u_peer.send(9'h055, 9, 0, 0, 0, 0, 0);
      cyc(4);
      chk("rx_full", 1'b0, rx_full_o);
      u_peer.send(9'h1aa, 9, 0, 0, 0, 0, 0);
      cyc(4);
      chk("rx_data", 9'h1aa, rx_data_o);
      {sleep_i, rx_en_i} <= 2'h0;
      clr();
      u_peer.send(9'h133, 9, 0, 0, 0, 0, 0);
      cyc(4);
      chk("rx_irqs", 9'h1, 9'(rx_irqs - b));
      rx_en_i <= 1'b1;
   endtask
   task automatic t_fifo();
      cfg(2'h1, 0, 0, 0);
      tx_en_i <= 1'b0;
      for (int i = 0; i < 8; i++) wr(9'(i * 3));
      cyc(2);
      chk("tx_ready", 1'b0, tx_ready_o);
      chk("serial_out", 1'b1, serial_out_o);
      tx_en_i <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         u_peer.recv(8, 0, d, p, s);
         chk("fifo_data", 9'(i * 3), d);
      end
      cyc(BIT);
      chk("tx_buf_empty", 1'b1, tx_buf_empty_o);
   endtask
   task automatic t_rate();
      time t;
      for (int i = 0; i < 2; i++) begin
         // /8 tap with n = 0, then the pin clock with n = 1: both give 128 cycles a bit
         {src_sel_i, brg_div_i, ext_clk_sel_i} <= (i == 0) ? 11'h200 : 11'h003;
         wr(9'h001);
         @(posedge line);
         t = $time;
         @(negedge line);
         chk("bit_cycles", 9'h080, 9'(($time - t) / 8));
         chk("clock_port", 9'(i == 0), ext_rate_clock_port_o);
         @(posedge line);
         cyc(5 * BIT);
      end
   endtask
   task automatic end_sim();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      {parity_en_i, parity_odd_i, two_stop_i, ext_clk_sel_i, tx_int_cause_i, sleep_i} = '0;
      {open_drain_i, tx_valid_i, rx_read_i, err_clr_i} = '0;
      {subclock_tap_i, char_len_i, src_sel_i, tx_data_i} = '0;
      {uart_mode_i, tx_en_i, rx_en_i, srst_i} = 4'hf;
      brg_div_i = 8'h01;
      cyc(16);
      srst_i <= 1'b0;
      cyc(3);
      t_idle();
      t_tx();
      t_rx();
      t_err();
      t_ovr();
      t_sleep();
      t_fifo();
      t_rate();
      end_sim();
   end
   initial begin
      cyc(40000);
      errors++;
      end_sim();
   end
endmodule // uart_channel_tb
